/* File: fsb_map.vh */
`ifndef FSB_MAP_VH
`define FSB_MAP_VH

// register offsets (byte addresses, 8-bit registers)
`define FSB_REG_SECCFG 5'h01
`define FSB_REG_CMDIDX 5'h02
`define FSB_REG_CTRL 5'h04
`define FSB_REG_MARGIN 5'h05
`define FSB_REG_STATUS 5'h06
`define FSB_REG_CMDOBJ_HI 5'h0A
`define FSB_REG_CMDOBJ_LO 5'h0B
`define FSB_REG_LAST 5'h13

// field positions
`define FSB_SEC_LSB 0
`define FSB_BACKDOOR_ENABLE_FIELD_LSB 6
`define FSB_ST_COMMAND_COMPLETE_FLAG 7
`define FSB_ST_ACCESS_ERROR_FLAG 5
`define FSB_ST_PROTECTION_VIOLATION_FLAG 4
`define FSB_CTRL_RESWIN 0

// field values
`define FSB_SEC_UNSECURED 2'h2
`define FSB_BACKDOOR_ENABLE_FIELD_ENABLED 2'h2
`define FSB_BLK_EEPROM 2'h0
`define FSB_BLK_INVALID 2'h1

// reset values
`define FSB_SECCFG_RST 8'h00
`define FSB_MARGIN_RST 2'h0

// command codes and index values
`define FSB_CMD_VERIFY_KEY 8'h0C
`define FSB_CMD_SET_MARGIN 8'h0D
`define FSB_IDX_KEY_LAST 3'h4
`define FSB_IDX_MARGIN 3'h1
`define FSB_KEY_COUNT 2'h3

// nonvolatile addresses
`define FSB_NV_SEC_BYTE 18'h3FF0F
`define FSB_NV_KEY_BASE 18'h3FF00

// resource window
`define FSB_IFR_LO 18'h04000
`define FSB_IFR_HI 18'h040FF
`define FSB_RESV_LO 18'h04100
`define FSB_RESV_HI 18'h07FFF

// invalid data returned while keys are compared
`define FSB_INVALID_DATA 16'hFFFF

`endif

/* File: fsb_security.v */
`timescale 1ns/10ps
`include "fsb_map.vh"

// Function
// - memory runs on in wait; command-complete level can wake the core
// - stop is acknowledged only after a running command has finished
// - security config register loads from security byte 0x3_FF0F at reset
// - new security byte value acts only after the next reset
// - current security state is a continuous status output
// - four 16-bit stored keys sit at 0x3_FF00 to 0x3_FF07
// - array reads return invalid data while key verify runs
// - verify checks backdoor enable at launch, error and stop if disabled
// - backdoor enabled only when enable field equals 10
// - all four keys compared in order; security released on full match
// - after a mismatch every later verify aborts with error until reset
// - incorrect key set sets the access error flag
// - verify with command index not 100 sets the access error flag
// - command-complete flag set again when verify finishes
// - command 0x0D sets read margin level of the selected block
// - block code 00 EEPROM, 01 invalid with error, 10/11 program flash
// - seven registers decoded within offsets 0x00 to 0x13
// - resource window maps 256-byte info row at 0x0_4000, rest reserved
module fsb_security (
  // clock and reset
  input wire CLOCK,
  input wire RST_N,
  // register port
  input wire [4:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  // nonvolatile array read port, data valid in the same cycle as the request
  output reg NV_RD,
  output reg [17:0] NV_ADDR,
  input wire [15:0] NV_RDATA,
  // core array read path
  input wire [17:0] CPU_ADDR,
  input wire [15:0] ARRAY_DATA,
  output reg [15:0] CPU_RDATA,
  output reg IFR_HIT,
  output reg RESERVED_HIT,
  // mode and security status
  input wire STOP_REQ,
  output reg STOP_ACK,
  output reg CMD_COMPLETE,
  output reg SECURED,
  output reg [1:0] PFLASH_MARGIN,
  output reg [1:0] EEPROM_MARGIN
);

  localparam [2:0] ST_LOAD = 3'h0;
  localparam [2:0] ST_LOAD_WAIT = 3'h1;
  localparam [2:0] ST_IDLE = 3'h2;
  localparam [2:0] ST_KEY_RD = 3'h3;
  localparam [2:0] ST_KEY_CMP = 3'h4;
  localparam [2:0] ST_DONE = 3'h5;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [7:0] seccfg_q;
  reg [7:0] seccfg_d;
  reg [2:0] cmdidx_q;
  reg [2:0] cmdidx_d;
  reg [15:0] cmdobj_q [0:4];
  reg reswin_q;
  reg command_complete_flag_q;
  reg command_complete_flag_d;
  reg access_error_flag_q;
  reg access_error_flag_d;
  reg protection_violation_flag_q;
  reg protection_violation_flag_d;
  reg locked_q;
  reg locked_d;
  reg mismatch_q;
  reg mismatch_d;
  reg [1:0] keynum_q;
  reg [1:0] keynum_d;
  reg [1:0] pmargin_d;
  reg [1:0] emargin_d;
  reg nv_rd_d;
  reg [17:0] nv_addr_d;
  reg stop_meta_q;
  reg stop_sync_q;
  reg [7:0] rdata_d;
  reg err_launch;

  function in_win;
    input [17:0] a;
    input [17:0] lo;
    input [17:0] hi;
    begin
      in_win = (a >= lo) && (a <= hi);
    end
  endfunction

  function reg_hit;
    input [4:0] a;
    input [4:0] off;
    begin
      reg_hit = (a == off);
    end
  endfunction

  wire [7:0] cmd_code = cmdobj_q[0][15:8];
  wire [1:0] backdoor_enable_field = seccfg_q[`FSB_BACKDOOR_ENABLE_FIELD_LSB+1:`FSB_BACKDOOR_ENABLE_FIELD_LSB];
  wire [15:0] cur_key = cmdobj_q[{1'b0, keynum_q} + 3'h1];
  wire [7:0] status_val = {command_complete_flag_q, 1'b0, access_error_flag_q, protection_violation_flag_q, 4'h0};
  wire [1:0] blk = cmdobj_q[0][1:0];

  // register writes from the bus; launch and error clears come via status
  wire launch = WR && reg_hit(ADDR, `FSB_REG_STATUS) &&
    WDATA[`FSB_ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_q && !access_error_flag_q && !protection_violation_flag_q &&
    state_q == ST_IDLE;

  // command sequencer
  always @*
  begin
    state_d = state_q;
    seccfg_d = seccfg_q;
    command_complete_flag_d = command_complete_flag_q;
    access_error_flag_d = access_error_flag_q;
    protection_violation_flag_d = protection_violation_flag_q;
    locked_d = locked_q;
    mismatch_d = mismatch_q;
    keynum_d = keynum_q;
    pmargin_d = PFLASH_MARGIN;
    emargin_d = EEPROM_MARGIN;
    nv_rd_d = 1'b0;
    nv_addr_d = NV_ADDR;
    err_launch = 1'b0;
    cmdidx_d = cmdidx_q;
    if (WR && command_complete_flag_q && reg_hit(ADDR, `FSB_REG_CMDIDX))
      cmdidx_d = WDATA[2:0];
    // software clears error flags by writing one; hardware sets win below
    if (WR && reg_hit(ADDR, `FSB_REG_STATUS) && WDATA[`FSB_ST_ACCESS_ERROR_FLAG])
      access_error_flag_d = 1'b0;
    if (WR && reg_hit(ADDR, `FSB_REG_STATUS) && WDATA[`FSB_ST_PROTECTION_VIOLATION_FLAG])
      protection_violation_flag_d = 1'b0;
    case (state_q)
      ST_LOAD:
      begin
        nv_rd_d = 1'b1;
        nv_addr_d = `FSB_NV_SEC_BYTE;
        state_d = ST_LOAD_WAIT;
      end
      ST_LOAD_WAIT:
      begin
        // only loaded here, so a reprogrammed byte waits for reset
        seccfg_d = NV_RDATA[7:0];
        command_complete_flag_d = 1'b1;
        state_d = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (launch)
        begin
          case (cmd_code)
            `FSB_CMD_VERIFY_KEY:
            begin
              if (cmdidx_q != `FSB_IDX_KEY_LAST)
                err_launch = 1'b1;
              else if (backdoor_enable_field != `FSB_BACKDOOR_ENABLE_FIELD_ENABLED)
                err_launch = 1'b1;
              else if (locked_q)
                err_launch = 1'b1;
              else
              begin
                command_complete_flag_d = 1'b0;
                keynum_d = 2'h0;
                mismatch_d = 1'b0;
                state_d = ST_KEY_RD;
              end
            end
            `FSB_CMD_SET_MARGIN:
            begin
              if (cmdidx_q != `FSB_IDX_MARGIN)
                err_launch = 1'b1;
              else if (blk == `FSB_BLK_INVALID)
                err_launch = 1'b1;
              else if (blk == `FSB_BLK_EEPROM)
                emargin_d = cmdobj_q[1][1:0];
              else
                pmargin_d = cmdobj_q[1][1:0];
            end
            default:
              err_launch = 1'b1;
          endcase
          if (err_launch)
            access_error_flag_d = 1'b1;
        end
      end
      ST_KEY_RD:
      begin
        nv_rd_d = 1'b1;
        // one word per key, two bytes apart
        nv_addr_d = `FSB_NV_KEY_BASE + {15'h0, keynum_q, 1'b0};
        state_d = ST_KEY_CMP;
      end
      ST_KEY_CMP:
      begin
        if (NV_RDATA != cur_key)
          mismatch_d = 1'b1;
        if (keynum_q == `FSB_KEY_COUNT)
          state_d = ST_DONE;
        else
        begin
          keynum_d = keynum_q + 2'h1;
          state_d = ST_KEY_RD;
        end
      end
      ST_DONE:
      begin
        if (mismatch_q)
        begin
          access_error_flag_d = 1'b1;
          locked_d = 1'b1;
        end
        else
          seccfg_d[`FSB_SEC_LSB+1:`FSB_SEC_LSB] = `FSB_SEC_UNSECURED;
        command_complete_flag_d = 1'b1;
        state_d = ST_IDLE;
      end
      default:
        state_d = ST_LOAD;
    endcase
  end

  // index, command object and control writes are ignored while busy
  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cmdobj_q[0] <= 16'h0000;
      cmdobj_q[1] <= 16'h0000;
      cmdobj_q[2] <= 16'h0000;
      cmdobj_q[3] <= 16'h0000;
      cmdobj_q[4] <= 16'h0000;
      reswin_q <= 1'b0;
    end
    else if (WR && command_complete_flag_q)
    begin
      if (reg_hit(ADDR, `FSB_REG_CMDOBJ_HI) && cmdidx_q <= 3'h4)
        cmdobj_q[cmdidx_q][15:8] <= WDATA;
      if (reg_hit(ADDR, `FSB_REG_CMDOBJ_LO) && cmdidx_q <= 3'h4)
        cmdobj_q[cmdidx_q][7:0] <= WDATA;
      if (reg_hit(ADDR, `FSB_REG_CTRL))
        reswin_q <= WDATA[`FSB_CTRL_RESWIN];
    end
  end

  // read data, one cycle after the strobe; unmapped offsets read zero
  always @*
  begin
    rdata_d = 8'h00;
    if (RD && ADDR <= `FSB_REG_LAST)
      case (ADDR)
        `FSB_REG_SECCFG:
          rdata_d = seccfg_q;
        `FSB_REG_CMDIDX:
          rdata_d = {5'h00, cmdidx_q};
        `FSB_REG_CTRL:
          rdata_d = {7'h00, reswin_q};
        `FSB_REG_MARGIN:
          rdata_d = {4'h0, EEPROM_MARGIN, PFLASH_MARGIN};
        `FSB_REG_STATUS:
          rdata_d = status_val;
        `FSB_REG_CMDOBJ_HI:
          rdata_d = (cmdidx_q <= 3'h4) ? cmdobj_q[cmdidx_q][15:8] : 8'h00;
        `FSB_REG_CMDOBJ_LO:
          rdata_d = (cmdidx_q <= 3'h4) ? cmdobj_q[cmdidx_q][7:0] : 8'h00;
        default:
          rdata_d = 8'h00;
      endcase
  end

  // main state registers
  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q <= ST_LOAD;
      seccfg_q <= `FSB_SECCFG_RST;
      cmdidx_q <= 3'h0;
      command_complete_flag_q <= 1'b0;
      access_error_flag_q <= 1'b0;
      protection_violation_flag_q <= 1'b0;
      locked_q <= 1'b0;
      mismatch_q <= 1'b0;
      keynum_q <= 2'h0;
      PFLASH_MARGIN <= `FSB_MARGIN_RST;
      EEPROM_MARGIN <= `FSB_MARGIN_RST;
      NV_RD <= 1'b0;
      NV_ADDR <= 18'h00000;
      RDATA <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      seccfg_q <= seccfg_d;
      cmdidx_q <= cmdidx_d;
      command_complete_flag_q <= command_complete_flag_d;
      access_error_flag_q <= access_error_flag_d;
      protection_violation_flag_q <= protection_violation_flag_d;
      locked_q <= locked_d;
      mismatch_q <= mismatch_d;
      keynum_q <= keynum_d;
      PFLASH_MARGIN <= pmargin_d;
      EEPROM_MARGIN <= emargin_d;
      NV_RD <= nv_rd_d;
      NV_ADDR <= nv_addr_d;
      RDATA <= rdata_d;
    end
  end

  // stop request arrives from another domain
  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      stop_meta_q <= 1'b0;
      stop_sync_q <= 1'b0;
    end
    else
    begin
      stop_meta_q <= STOP_REQ;
      stop_sync_q <= stop_meta_q;
    end
  end

  // status outputs, array read path and resource window decode
  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      STOP_ACK <= 1'b0;
      CMD_COMPLETE <= 1'b0;
      SECURED <= 1'b1;
      CPU_RDATA <= 16'h0000;
      IFR_HIT <= 1'b0;
      RESERVED_HIT <= 1'b0;
    end
    else
    begin
      // running command finishes before stop is granted
      STOP_ACK <= stop_sync_q && command_complete_flag_q && state_q == ST_IDLE;
      // level stays usable as a wake source while the core waits
      CMD_COMPLETE <= command_complete_flag_q;
      SECURED <= seccfg_q[`FSB_SEC_LSB+1:`FSB_SEC_LSB] !=
                 `FSB_SEC_UNSECURED;
      if (state_q == ST_KEY_RD || state_q == ST_KEY_CMP ||
          state_q == ST_DONE)
        CPU_RDATA <= `FSB_INVALID_DATA;
      else
        CPU_RDATA <= ARRAY_DATA;
      IFR_HIT <= reswin_q && in_win(CPU_ADDR, `FSB_IFR_LO,
                                    `FSB_IFR_HI);
      RESERVED_HIT <= reswin_q && in_win(CPU_ADDR, `FSB_RESV_LO,
                                         `FSB_RESV_HI);
    end
  end

endmodule

/* File: fsb_nvm_model.sv */
`timescale 1ns/10ps
// array behind the read port: data stand while the request does, noise idle
module fsb_nvm_model (
  // clock
  input wire clk,
  // read port
  input wire nv_rd,
  input wire [17:0] nv_addr,
  output reg [15:0] nv_rdata,
  // stored contents
  input wire [7:0] sec_byte,
  input wire [63:0] keys
);
  reg [15:0] noise = 16'hA5A5;
  always @(posedge clk)
    noise <= ~noise;
  // the controller samples at the edge that ends its request cycle
  always @*
  begin
    nv_rdata = noise;
    if (nv_rd && nv_addr == 18'h3FF0F)
      nv_rdata = {8'hFF, sec_byte};
    else if (nv_rd && nv_addr[17:3] == 15'h7FE0)
      nv_rdata = keys[{nv_addr[2:1], 4'h0} +: 16];
  end
endmodule

/* File: fsb_security_props.sv */
`timescale 1ns/10ps
module fsb_security_props (
  // clock and reset
  input wire CLOCK,
  input wire RST_N,
  // register read
  input wire [4:0] ADDR,
  input wire RD,
  input wire [7:0] RDATA,
  // array ports
  input wire NV_RD,
  input wire [17:0] NV_ADDR,
  input wire [15:0] NV_RDATA,
  input wire [17:0] CPU_ADDR,
  input wire [15:0] ARRAY_DATA,
  input wire [15:0] CPU_RDATA,
  input wire IFR_HIT,
  // status
  input wire STOP_ACK,
  input wire CMD_COMPLETE,
  input wire SECURED
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  boot_read_a: assert property ($rose(RST_N) |=> NV_RD &&
    NV_ADDR == 18'h3FF0F) else $error("no boot read");
  sec_load_a: assert property (NV_RD && NV_ADDR == 18'h3FF0F |=> ##1
    SECURED == ($past(NV_RDATA[1:0], 2) != 2'h2)) else $error("bad state");
  sec_hold_a: assert property (!SECURED |=> !SECURED)
    else $error("security came back");
  busy_data_a: assert property ($fell(CMD_COMPLETE) |=>
    (CPU_RDATA == 16'hFFFF) [*6]) else $error("array data leaked");
  data_back_a: assert property ($rose(CMD_COMPLETE) |=>
    CPU_RDATA == $past(ARRAY_DATA)) else $error("data not restored");
  verify_len_a: assert property ($fell(CMD_COMPLETE) |->
    !CMD_COMPLETE [*7] ##[1:4] CMD_COMPLETE) else $error("bad busy time");
  key_order_a: assert property (NV_RD && NV_ADDR == 18'h3FF00 |->
    ##2 NV_RD && NV_ADDR == 18'h3FF02 ##2 NV_RD && NV_ADDR == 18'h3FF04
    ##2 NV_RD && NV_ADDR == 18'h3FF06) else $error("key order");
  stop_done_a: assert property (STOP_ACK |-> CMD_COMPLETE)
    else $error("stop while busy");
  ifr_window_a: assert property (IFR_HIT |->
    $past(CPU_ADDR[17:8]) == 10'h040) else $error("window hit");
  read_idle_a: assert property (!$past(RD) || $past(ADDR) > 5'h13 |->
    RDATA == 8'h00) else $error("stray read data");
endmodule
bind fsb_security fsb_security_props u_props (.CLOCK(CLOCK), .RST_N(RST_N),
  .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .NV_RD(NV_RD), .NV_ADDR(NV_ADDR),
  .NV_RDATA(NV_RDATA), .CPU_ADDR(CPU_ADDR), .ARRAY_DATA(ARRAY_DATA),
  .CPU_RDATA(CPU_RDATA), .IFR_HIT(IFR_HIT), .STOP_ACK(STOP_ACK),
  .CMD_COMPLETE(CMD_COMPLETE), .SECURED(SECURED));

/* File: fsb_security_tb.sv */
`timescale 1ns/10ps
module fsb_security_tb;
  reg clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, stop_req = 0, rd_seen = 0;
  reg [4:0] addr = 0;
  reg [7:0] wdata = 0, sec_byte = 8'h80;
  reg [17:0] cpu_addr = 0;
  reg [15:0] array_data = 0;
  reg [63:0] keys = 0;
  reg [1:0] lv = 0, em = 0, pm = 0;
  wire [7:0] rdata;
  wire [17:0] nv_addr;
  wire [15:0] nv_rdata, cpu_rdata;
  wire [1:0] pf_m, ee_m;
  wire nv_rd, ifr_hit, res_hit, stop_ack, cmd_done, secured;
  int fail_count = 0;
  int checks_done = 0;
  logic [7:0] exp_q[$];
  logic [17:0] wins [6] = '{18'h04000, 18'h040FF, 18'h04100, 18'h07FFF,
    18'h08000, 18'h03FFF};
  always #5 clk = ~clk;
  fsb_security dut (.CLOCK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr_en), .RD(rd_en), .RDATA(rdata), .NV_RD(nv_rd), .NV_ADDR(nv_addr),
    .NV_RDATA(nv_rdata), .CPU_ADDR(cpu_addr), .ARRAY_DATA(array_data),
    .CPU_RDATA(cpu_rdata), .IFR_HIT(ifr_hit), .RESERVED_HIT(res_hit),
    .STOP_REQ(stop_req), .STOP_ACK(stop_ack), .CMD_COMPLETE(cmd_done),
    .SECURED(secured), .PFLASH_MARGIN(pf_m), .EEPROM_MARGIN(ee_m));
  fsb_nvm_model nvm (.clk(clk), .nv_rd(nv_rd), .nv_addr(nv_addr),
    .nv_rdata(nv_rdata), .sec_byte(sec_byte), .keys(keys));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input [4:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input [4:0] a, input [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    rd_seen <= rd_en;
    array_data <= 16'($urandom);
    if (rd_seen)
      chk(rdata, exp_q.pop_front());
  end
  task automatic settle;
    int n = 0;
    repeat (3) @(posedge clk);
    while (cmd_done !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    chk(cmd_done, 1'b1);
  endtask
  task automatic setw(input [2:0] i, input [15:0] w);
    wr(5'h02, {5'h00, i});
    wr(5'h0A, w[15:8]);
    wr(5'h0B, w[7:0]);
  endtask
  task automatic verify(input [2:0] last, input [63:0] k);
    setw(3'h0, 16'h0C00);
    for (int i = 0; i < 4; i++)
      setw(3'(i + 1), k[i*16 +: 16]);
    wr(5'h02, {5'h00, last});
    wr(5'h06, 8'h80);
    settle;
  endtask
  task automatic reboot(input [7:0] s);
    @(posedge clk);
    sec_byte <= s;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    settle;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up;
  end
  initial
  begin
    void'($urandom(96173));
    for (int i = 0; i < 4; i++)
      keys[i*16 +: 16] = 16'($urandom_range(16'hFFFE, 16'h0001));
    reboot(8'h80);
    chk(secured, 1'b1);
    rd(5'h01, 8'h80);
    rd(5'h15, 8'h00);
    sec_byte <= 8'h82;
    rd(5'h01, 8'h80);
    $display("boot test done");
    for (int e = 0; e < 4; e++)
    begin
      reboot({e[1:0], 6'h00});
      verify(3'h4, keys);
      chk(secured, e != 2);
      rd(5'h06, e == 2 ? 8'h80 : 8'hA0);
      rd(5'h01, e == 2 ? 8'h82 : {e[1:0], 6'h00});
    end
    $display("enable test done");
    reboot(8'h80);
    verify(3'h3, keys);
    rd(5'h06, 8'hA0);
    wr(5'h06, 8'h20);
    stop_req <= 1'b1;
    verify(3'h4, keys ^ 64'h1);
    @(posedge clk);
    chk(stop_ack, 1'b1);
    chk(secured, 1'b1);
    rd(5'h06, 8'hA0);
    stop_req <= 1'b0;
    wr(5'h06, 8'h20);
    verify(3'h4, keys);
    chk(secured, 1'b1);
    rd(5'h06, 8'hA0);
    wr(5'h06, 8'h20);
    $display("lockout test done");
    for (int b = 0; b < 4; b++)
    begin
      lv = 2'($urandom);
      setw(3'h0, {8'h0D, 6'h00, b[1:0]});
      setw(3'h1, {14'h0000, lv});
      wr(5'h06, 8'h80);
      settle;
      if (b == 0)
        em = lv;
      else if (b > 1)
        pm = lv;
      chk(ee_m, em);
      chk(pf_m, pm);
      rd(5'h05, {4'h0, em, pm});
      rd(5'h06, b == 1 ? 8'hA0 : 8'h80);
      wr(5'h06, 8'h20);
    end
    $display("margin test done");
    for (int w = 0; w < 2; w++)
    begin
      wr(5'h04, 8'(w));
      foreach (wins[i])
      begin
        @(posedge clk);
        cpu_addr <= wins[i];
        repeat (2) @(posedge clk);
        chk(ifr_hit, w == 1 && wins[i][17:8] == 10'h040);
        chk(res_hit, w == 1 && wins[i] > 18'h040FF &&
          wins[i] < 18'h08000);
      end
    end
    $display("window test done");
    repeat (3) @(posedge clk);
    wrap_up;
  end
endmodule
